// ---- rtl/preset_ref_consts.svh ----
// constants of the preset speed reference selector
`ifndef PRESET_REF_CONSTS_SVH
`define PRESET_REF_CONSTS_SVH
`define PRESET_REF_WIDTH 16
`define PRESET_COUNT 16
`define PRESET_MAX_VALUE 16'h9C40
`define PRESET_DEFAULT 16'h0000
`define JOG_DEFAULT 16'h0258
`define SRC_PANEL 2'h0
`define SRC_FIRST_ANALOG 2'h1
`define SECOND_ANALOG_AUX 5'h02
`define ADDR_WIDTH 8
`define OFS_PRESET_BASE 8'h00
`define OFS_JOG 8'h10
`define OFS_SOURCE 8'h11
`define OFS_SECOND_FUNC 8'h12
`define OFS_MAX_OUTPUT 8'h13
`define OFS_UPPER_LIMIT 8'h14
`define OFS_STATUS 8'h15
`define OFS_ACTIVE_REF 8'h16
`define MAX_OUTPUT_DEFAULT 16'h1770
`define UPPER_LIMIT_DEFAULT 16'h03E8
`define UPPER_LIMIT_FULL 16'h03E8
`endif

// ---- rtl/preset_ref_pkg.sv ----
// types of the preset speed reference selector
package preset_ref_pkg;
    typedef enum logic [1:0] {
        sel_idle,
        sel_preset,
        sel_jog
    } sel_mode_t;
endpackage

// ---- rtl/preset_speed_reference_selector.sv ----
// preset speed reference selector: presets, jog and analog substitution
// Contract
// - seventeen references are held, sixteen numbered presets and one jog reference, each selectable.
// - the selection may change while running and the downstream ramp uses the active accel or decel time.
// - the jog input alone picks the jog reference and then overrides every numbered preset.
// - numbered presets range from 0.00 to 400.00 Hz and reset to 0.00 Hz.
// - jog resets to 6.00 Hz and is capped by the lower of max output frequency and the upper limit.
// - reference source 1 makes preset 1 follow the first analog input, source 0 the stored value.
// - second analog function 2 makes preset 2 follow the second analog input, else the stored value.
// - with jog off the chosen preset is 1 + s1 + 2*s2 + 4*s3 + 8*s4, all off giving preset 1.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "preset_ref_consts.svh"
module preset_speed_reference_selector
    import preset_ref_pkg::*;
#(
    parameter int WIDTH = `PRESET_REF_WIDTH,
    parameter int COUNT = `PRESET_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // select inputs from switches or controller
    input wire logic [3:0] step_sel,
    input wire logic jog_sel,
    // analog inputs, same scale as references (0.01 Hz per lsb)
    input wire logic [WIDTH-1:0] first_analog_input,
    input wire logic [WIDTH-1:0] second_analog_input,
    // register port
    input wire logic [`ADDR_WIDTH-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // active reference
    output logic [WIDTH-1:0] active_ref,
    output logic [4:0] active_index,
    output logic jog_active
);
    // the address and step decoders are written for exactly sixteen 16-bit presets
    if (WIDTH != 16 || COUNT != 16) begin : g_bad_size
        $error("preset selector supports only 16 presets of 16 bits");
    end

    logic [WIDTH-1:0] preset_val [COUNT];
    logic [WIDTH-1:0] jog_val;
    logic [1:0] ref_src_q;
    logic [4:0] second_func_q;
    logic [15:0] max_out_q;
    logic [15:0] upper_lim_q;
    logic [WIDTH-1:0] ref_q;
    logic [WIDTH-1:0] ref_d;
    logic [4:0] index_q;
    logic [4:0] index_d;
    sel_mode_t mode_q;
    sel_mode_t mode_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    wire wr_preset = reg_wr && (reg_addr < `OFS_JOG);
    wire wr_jog = reg_wr && (reg_addr == `OFS_JOG);
    wire wr_src = reg_wr && (reg_addr == `OFS_SOURCE);
    wire wr_func = reg_wr && (reg_addr == `OFS_SECOND_FUNC);
    wire wr_max = reg_wr && (reg_addr == `OFS_MAX_OUTPUT);
    wire wr_lim = reg_wr && (reg_addr == `OFS_UPPER_LIMIT);

    // jog ceiling: upper limit is in 0.1 percent of max output frequency
    wire [31:0] lim_prod = 32'(max_out_q) * 32'(upper_lim_q);
    wire [15:0] lim_scaled = 16'(lim_prod / 32'd1000);
    wire [15:0] jog_cap_raw = (lim_scaled < max_out_q) ? lim_scaled : max_out_q;
    wire [15:0] jog_cap = (jog_cap_raw > `PRESET_MAX_VALUE) ? `PRESET_MAX_VALUE : jog_cap_raw;

    genvar gi;
    generate
        for (gi = 0; gi < COUNT; gi++) begin : g_preset
            wire wr_this = wr_preset && (reg_addr[3:0] == 4'(gi));
            preset_store #(
                .WIDTH(WIDTH),
                .RESET_VALUE(`PRESET_DEFAULT)
            ) u_store (
                .clk(clk),
                .nrst(nrst),
                .wr_en(wr_this),
                .wr_data(reg_wdata),
                .max_value(`PRESET_MAX_VALUE),
                .value(preset_val[gi])
            );
        end
    endgenerate

    preset_store #(
        .WIDTH(WIDTH),
        .RESET_VALUE(`JOG_DEFAULT)
    ) u_jog (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_jog),
        .wr_data(reg_wdata),
        .max_value(jog_cap),
        .value(jog_val)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_src_q <= `SRC_PANEL;
            second_func_q <= 5'h00;
            max_out_q <= `MAX_OUTPUT_DEFAULT;
            upper_lim_q <= `UPPER_LIMIT_DEFAULT;
        end else begin
            if (wr_src) ref_src_q <= reg_wdata[1:0];
            if (wr_func) second_func_q <= reg_wdata[4:0];
            if (wr_max) max_out_q <= reg_wdata;
            if (wr_lim) upper_lim_q <= reg_wdata;
        end
    end

    // analog substitution for presets 1 and 2
    wire use_first_analog = (ref_src_q == `SRC_FIRST_ANALOG);
    wire use_second_analog = (second_func_q == `SECOND_ANALOG_AUX);
    wire [WIDTH-1:0] preset1 = use_first_analog ? first_analog_input : preset_val[0];
    wire [WIDTH-1:0] preset2 = use_second_analog ? second_analog_input : preset_val[1];

    // binary weighted step select, zero-based index equals s1+2s2+4s3+8s4
    wire [3:0] step_idx = step_sel;
    wire [WIDTH-1:0] step_val = (step_idx == 4'h0) ? preset1 :
                                (step_idx == 4'h1) ? preset2 : preset_val[step_idx];
    // jog beats every step pattern; a stored jog may exceed a later lowered cap, so clamp here too
    wire [WIDTH-1:0] jog_eff = (jog_val > jog_cap) ? jog_cap : jog_val;

    always_comb begin
        mode_d = sel_preset;
        ref_d = step_val;
        index_d = {1'b0, step_idx} + 5'h01;
        case (jog_sel)
            1'b1: begin
                mode_d = sel_jog;
                ref_d = jog_eff;
                index_d = 5'h11;
            end
            default: begin
                mode_d = sel_preset;
            end
        endcase
    end

    // selection is registered only; ramping happens downstream at the active accel/decel time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_q <= `PRESET_DEFAULT;
            index_q <= 5'h01;
            mode_q <= sel_idle;
        end else begin
            ref_q <= ref_d;
            index_q <= index_d;
            mode_q <= mode_d;
        end
    end

    // register read
    wire rd_preset = reg_addr < `OFS_JOG;
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_preset) begin
            rdata_d = preset_val[reg_addr[3:0]];
        end else begin
            case (reg_addr)
                `OFS_JOG: rdata_d = jog_val;
                `OFS_SOURCE: rdata_d = {14'h0000, ref_src_q};
                `OFS_SECOND_FUNC: rdata_d = {11'h000, second_func_q};
                `OFS_MAX_OUTPUT: rdata_d = max_out_q;
                `OFS_UPPER_LIMIT: rdata_d = upper_lim_q;
                `OFS_STATUS: rdata_d = {10'h000, (mode_q == sel_jog), index_q};
                `OFS_ACTIVE_REF: rdata_d = ref_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign active_ref = ref_q;
    assign active_index = index_q;
    assign jog_active = (mode_q == sel_jog);
endmodule // preset_speed_reference_selector
`default_nettype wire

// ---- rtl/preset_store.sv ----
// one stored preset reference with its range clamp
`timescale 1ns/10ps
`default_nettype none
`include "preset_ref_consts.svh"
module preset_store #(
    parameter int WIDTH = 16,
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write side
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH-1:0] max_value,
    // stored value
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;
    // out of range writes saturate so a bad write cannot overspeed
    assign value_d = (wr_data > max_value) ? max_value : wr_data;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            value_q <= RESET_VALUE[WIDTH-1:0];
        end else if (wr_en) begin
            value_q <= value_d;
        end
    end
    assign value = value_q;
endmodule // preset_store
`default_nettype wire

// ---- verif/preset_ref_props.sv ----
// port assertions of the preset reference selector
`timescale 1ns/10ps
`default_nettype none
`include "preset_ref_consts.svh"
module preset_ref_props #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // selection inputs
    input wire logic [3:0] step_sel,
    input wire logic jog_sel,
    input wire logic [WIDTH-1:0] first_analog_input,
    input wire logic [WIDTH-1:0] second_analog_input,
    // register port
    input wire logic [`ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // outputs
    input wire logic [WIDTH-1:0] active_ref,
    input wire logic [4:0] active_index,
    input wire logic jog_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_jog_override: assert property (jog_sel |=> active_index == 5'h11 && jog_active)
        else $error("jog not selected");
    chk_step_decode: assert property (!jog_sel |=> !jog_active && active_index == $past(step_sel) + 5'h01)
        else $error("wrong preset index");
    chk_index_range: assert property (active_index inside {[5'h01:5'h11]})
        else $error("index out of range");
    chk_preset_range: assert property (active_index > 5'h02 && !jog_active |-> active_ref <= `PRESET_MAX_VALUE)
        else $error("preset above range");
    chk_jog_cap: assert property (jog_active |-> active_ref <= `MAX_OUTPUT_DEFAULT || active_ref <= `PRESET_MAX_VALUE)
        else $error("jog above cap");
    chk_reset_state: assert property (@(posedge clk) disable iff (1'b0)
        !nrst |=> active_index == 5'h01 && active_ref == 16'h0000 && !jog_active) else $error("bad reset state");
    // a write may move the cap or a preset, so only quiet cycles are held steady
    chk_hold_steady: assert property ($past(nrst) && !$past(reg_wr) && $stable(step_sel) && $stable(jog_sel)
        && $stable(first_analog_input) && $stable(second_analog_input) |=> $stable(active_ref)) else $error("ref moved");
    chk_read_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read");
    cover property (jog_active);
    cover property (active_index == 5'h10);
    cover property (reg_rd && reg_addr == `OFS_JOG);
endmodule // preset_ref_props
bind preset_speed_reference_selector preset_ref_props #(.WIDTH(WIDTH)) props (.clk(clk), .nrst(nrst),
    .step_sel(step_sel), .jog_sel(jog_sel), .first_analog_input(first_analog_input),
    .second_analog_input(second_analog_input), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .active_ref(active_ref), .active_index(active_index), .jog_active(jog_active));
`default_nettype wire

// ---- verif/switch_panel.sv ----
// model of the switch panel driving the select inputs
`timescale 1ns/10ps
`default_nettype none
module switch_panel (
    // requested position
    input wire logic [3:0] want_step,
    input wire logic want_jog,
    // select lines
    output logic [3:0] step_sel,
    output logic jog_sel
);
    // bit n is select function n+1: codes 3, 4, 5, 32 in order
    assign step_sel = want_step;
    assign jog_sel = want_jog;
endmodule // switch_panel
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the preset reference selector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] want_step = 4'h0;
    logic want_jog = 1'b0;
    logic [3:0] step_sel;
    logic jog_sel;
    logic [15:0] ana1 = 16'h0000;
    logic [15:0] ana2 = 16'h0000;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] active_ref;
    logic [4:0] active_index;
    logic jog_active;
    int n_errors = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    switch_panel panel (.want_step(want_step), .want_jog(want_jog), .step_sel(step_sel), .jog_sel(jog_sel));
    preset_speed_reference_selector dut (.clk(clk), .nrst(nrst), .step_sel(step_sel), .jog_sel(jog_sel),
        .first_analog_input(ana1), .second_analog_input(ana2), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_ref(active_ref),
        .active_index(active_index), .jog_active(jog_active));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [15:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, want);
    endtask
    task automatic sel(input logic [3:0] s, input logic j, input logic [4:0] idx, input logic [15:0] r);
        @(posedge clk);
        want_step <= s;
        want_jog <= j;
        @(posedge clk);
        #1 check({10'h000, jog_active, active_index}, {10'h000, j, idx});
        check(active_ref, r);
    endtask
    initial begin
        #100000 n_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 16; i++) rdchk(8'(i), 16'h0000);
        rdchk(8'h10, 16'h0258);
        sel(4'h0, 1'b0, 5'h01, 16'h0000);
        for (int i = 0; i < 15; i++) wr(8'(i), 16'(100 * (i + 1)));
        wr(8'h0f, 16'hffff);
        for (int i = 0; i < 15; i++) sel(4'(i), 1'b0, 5'(i + 1), 16'(100 * (i + 1)));
        sel(4'hf, 1'b0, 5'h10, 16'h9c40);
        sel(4'h5, 1'b1, 5'h11, 16'h0258);
        wr(8'h10, 16'hffff);
        sel(4'hf, 1'b1, 5'h11, 16'h1770);
        rdchk(8'h15, 16'h0031);
        rdchk(8'h16, 16'h1770);
        // half the upper limit lowers the cap under the stored jog value
        wr(8'h14, 16'h01f4);
        sel(4'h0, 1'b1, 5'h11, 16'h0bb8);
        // a lower max output frequency now sets the cap through the limit percentage
        wr(8'h13, 16'h07d0);
        rdchk(8'h13, 16'h07d0);
        sel(4'h0, 1'b1, 5'h11, 16'h03e8);
        sel(4'h3, 1'b0, 5'h04, 16'h0190);
        @(posedge clk);
        ana1 <= 16'h1234;
        ana2 <= 16'h0abc;
        wr(8'h11, 16'h0001);
        sel(4'h0, 1'b0, 5'h01, 16'h1234);
        wr(8'h11, 16'h0000);
        sel(4'h0, 1'b0, 5'h01, 16'h0064);
        wr(8'h12, 16'h0002);
        sel(4'h1, 1'b0, 5'h02, 16'h0abc);
        wr(8'h12, 16'h0003);
        sel(4'h1, 1'b0, 5'h02, 16'h00c8);
        wr(8'h20, 16'h5555);
        rdchk(8'h20, 16'h0000);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdchk(8'h01, 16'h0000);
        sel(4'h2, 1'b0, 5'h03, 16'h0000);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
